// *** design/lem_monitor.sv ***
// Link error event monitor: windows, thresholds, totals, register port
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module lem_monitor #(
    parameter int unsigned TICK_CYCLES = lem_pkg::TICK_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    input wire logic oam_reset_in,
    input wire lem_pkg::lem_port_obs_t obs_in,
    input wire lem_pkg::lem_bus_req_t bus_req_in,
    output logic [31:0] rdata_out,
    output logic [3:0] event_out,
    output logic [15:0] seq_out
);
    localparam int TW = $clog2(TICK_CYCLES);

    function automatic logic [15:0] clamp_win(input logic [15:0] v);
        if (v < lem_pkg::FRM_WIN_MIN) begin
            return lem_pkg::FRM_WIN_MIN;
        end else if (v > lem_pkg::FRM_WIN_MAX) begin
            return lem_pkg::FRM_WIN_MAX;
        end
        return v;
    endfunction : clamp_win

    function automatic logic win_done16(input logic [15:0] c,
                                        input logic [15:0] w);
        return ({1'b0, c} + 17'h00001) >= {1'b0, w};
    endfunction : win_done16

    logic [TW-1:0] tick_div;
    logic tick;
    logic [15:0] now;
    logic [15:0] frm_win;
    logic [31:0] frm_thr;
    logic [31:0] per_win;
    logic [31:0] per_thr;
    logic [63:0] sym_win;
    logic [63:0] sym_thr;
    logic [15:0] sec_win;
    logic [15:0] sec_thr;
    logic [15:0] frm_ticks;
    logic [31:0] frm_cnt;
    logic [63:0] frm_tot;
    logic [31:0] per_frames;
    logic [31:0] per_cnt;
    logic [63:0] per_tot;
    logic [63:0] sym_syms;
    logic [63:0] sym_cnt;
    logic [63:0] sym_tot;
    logic [3:0] sec_sub;
    logic sec_flag;
    logic [15:0] sec_ticks;
    logic [15:0] sec_cnt;
    logic [31:0] sec_tot;
    logic [15:0] ev_ts [lem_pkg::NUM_EV];
    logic [31:0] ev_cnt [lem_pkg::NUM_EV];
    logic [3:0] ev_raise;
    logic run;
    logic wr;
    logic frm_end, per_end, sym_end, sec_end, sec_tick_end, err_sec;
    logic [31:0] next_frm_cnt, next_per_cnt;
    logic [63:0] next_sym_cnt;
    logic [15:0] next_sec_cnt;
    logic [31:0] rd_mux;

    assign run = ce_in && !oam_reset_in;
    assign wr = ce_in && bus_req_in.wr;

    // 100 ms tick from the system clock
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tick_div <= '0;
            tick <= 1'b0;
        end else if (ce_in) begin
            if (tick_div == TW'(TICK_CYCLES - 1)) begin
                tick_div <= '0;
                tick <= 1'b1;
            end else begin
                tick_div <= tick_div + 1'b1;
                tick <= 1'b0;
            end
        end
    end

    // Free-running timestamp, untouched by the OAM reset
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            now <= '0;
        end else if (ce_in && tick) begin
            now <= now + 16'h0001; // [RULE2]
        end
    end

    // Configuration writes
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            frm_win <= lem_pkg::FRM_WIN_RST;
            frm_thr <= lem_pkg::FRM_THR_RST;
            per_win <= lem_pkg::PER_WIN_RST;
            per_thr <= lem_pkg::PER_THR_RST;
            sym_win <= lem_pkg::SYM_WIN_RST;
            sym_thr <= lem_pkg::SYM_THR_RST;
            sec_win <= lem_pkg::SEC_WIN_RST;
            sec_thr <= lem_pkg::SEC_THR_RST;
        end else if (wr) begin
            case (bus_req_in.addr)
                lem_pkg::A_FRM_WIN: begin
                    frm_win <= clamp_win(bus_req_in.wdata[15:0]); // [RULE3]
                end
                lem_pkg::A_FRM_THR: frm_thr <= bus_req_in.wdata;
                lem_pkg::A_PER_WIN: per_win <= bus_req_in.wdata;
                lem_pkg::A_PER_THR: per_thr <= bus_req_in.wdata;
                lem_pkg::A_SYM_WIN_LO: sym_win[31:0] <= bus_req_in.wdata;
                lem_pkg::A_SYM_WIN_HI: sym_win[63:32] <= bus_req_in.wdata;
                lem_pkg::A_SYM_THR_LO: sym_thr[31:0] <= bus_req_in.wdata;
                lem_pkg::A_SYM_THR_HI: sym_thr[63:32] <= bus_req_in.wdata;
                lem_pkg::A_SEC_WIN: sec_win <= bus_req_in.wdata[15:0];
                lem_pkg::A_SEC_THR: sec_thr <= bus_req_in.wdata[15:0];
                default: ;
            endcase
        end
    end

    // Window ends and the counts that they judge
    always_comb begin
        frm_end = tick && win_done16(frm_ticks, frm_win); // [RULE3]
        per_end = obs_in.frame &&
            ({1'b0, per_frames} + 33'h1 >= {1'b0, per_win}); // [RULE8]
        sym_end = obs_in.symbol &&
            ({1'b0, sym_syms} + 65'h1 >= {1'b0, sym_win}); // [RULE13]
        sec_end = tick && win_done16(sec_ticks, sec_win);
        sec_tick_end = tick && (sec_sub == lem_pkg::TICKS_PER_SEC - 4'h1);
        err_sec = sec_tick_end && (sec_flag || obs_in.frame_err); // [RULE21]
        next_frm_cnt = frm_cnt + {31'h0, obs_in.frame_err};
        next_per_cnt = per_cnt + {31'h0, obs_in.frame_err};
        next_sym_cnt = sym_cnt + {63'h0, obs_in.symbol_err};
        next_sec_cnt = sec_cnt + {15'h0, err_sec};
        ev_raise[lem_pkg::EV_FRM] = frm_end && next_frm_cnt >= frm_thr; // [RULE4]
        ev_raise[lem_pkg::EV_PER] = per_end && next_per_cnt >= per_thr; // [RULE9]
        ev_raise[lem_pkg::EV_SYM] = sym_end && next_sym_cnt >= sym_thr; // [RULE14]
        ev_raise[lem_pkg::EV_SEC] = sec_end && next_sec_cnt >= sec_thr; // [RULE18]
    end

    // Errored frame window
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            frm_ticks <= '0;
            frm_cnt <= '0;
            frm_tot <= '0;
        end else if (ce_in && oam_reset_in) begin
            frm_ticks <= '0;
            frm_cnt <= '0;
            frm_tot <= '0; // [RULE20]
        end else if (ce_in) begin
            frm_tot <= frm_tot + {63'h0, obs_in.frame_err}; // [RULE6]
            if (frm_end) begin
                frm_ticks <= '0;
                frm_cnt <= '0; // [RULE20]
            end else begin
                frm_ticks <= frm_ticks + {15'h0, tick};
                frm_cnt <= next_frm_cnt; // [RULE5]
            end
        end
    end

    // Frame period window
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            per_frames <= '0;
            per_cnt <= '0;
            per_tot <= '0;
        end else if (ce_in && oam_reset_in) begin
            per_frames <= '0;
            per_cnt <= '0;
            per_tot <= '0; // [RULE20]
        end else if (ce_in) begin
            per_tot <= per_tot + {63'h0, obs_in.frame_err}; // [RULE11]
            if (per_end) begin
                per_frames <= '0;
                per_cnt <= '0; // [RULE20]
            end else begin
                per_frames <= per_frames + {31'h0, obs_in.frame};
                per_cnt <= next_per_cnt; // [RULE10]
            end
        end
    end

    // Symbol period window
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sym_syms <= '0;
            sym_cnt <= '0;
            sym_tot <= '0;
        end else if (ce_in && oam_reset_in) begin
            sym_syms <= '0;
            sym_cnt <= '0;
            sym_tot <= '0; // [RULE20]
        end else if (ce_in) begin
            sym_tot <= sym_tot + {63'h0, obs_in.symbol_err}; // [RULE16]
            if (sym_end) begin
                sym_syms <= '0;
                sym_cnt <= '0; // [RULE20]
            end else begin
                sym_syms <= sym_syms + {63'h0, obs_in.symbol};
                sym_cnt <= next_sym_cnt; // [RULE15]
            end
        end
    end

    // Errored frame seconds summary window
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sec_sub <= '0;
            sec_flag <= 1'b0;
            sec_ticks <= '0;
            sec_cnt <= '0;
            sec_tot <= '0;
        end else if (ce_in && oam_reset_in) begin
            sec_sub <= '0;
            sec_flag <= 1'b0;
            sec_ticks <= '0;
            sec_cnt <= '0;
            sec_tot <= '0; // [RULE20]
        end else if (ce_in) begin
            sec_tot <= sec_tot + {31'h0, err_sec};
            if (sec_tick_end) begin
                sec_sub <= '0;
                sec_flag <= 1'b0;
            end else begin
                sec_sub <= sec_sub + {3'h0, tick};
                sec_flag <= sec_flag || obs_in.frame_err; // [RULE21]
            end
            if (sec_end) begin
                sec_ticks <= '0;
                sec_cnt <= '0; // [RULE20]
            end else begin
                sec_ticks <= sec_ticks + {15'h0, tick};
                sec_cnt <= next_sec_cnt; // [RULE19]
            end
        end
    end

    // Per-event stamp and event counters
    for (genvar i = 0; i < lem_pkg::NUM_EV; i++) begin : g_ev
        always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                ev_ts[i] <= '0;
                ev_cnt[i] <= '0;
            end else if (ce_in && oam_reset_in) begin
                ev_ts[i] <= '0;
                ev_cnt[i] <= '0; // [RULE20]
            end else if (ce_in && ev_raise[i]) begin
                ev_ts[i] <= now; // [RULE2]
                ev_cnt[i] <= ev_cnt[i] + 32'h0000_0001; // [RULE7] [RULE12] [RULE17]
            end
        end
    end

    // Event pulses and sequence number
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            event_out <= '0;
            seq_out <= '0;
        end else if (ce_in) begin
            event_out <= run ? ev_raise : 4'h0;
            if (oam_reset_in) begin
                seq_out <= '0;
            end else begin
                seq_out <= seq_out + 16'($countones(ev_raise)); // [RULE1]
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (bus_req_in.addr)
            lem_pkg::A_FRM_WIN: rd_mux = {16'h0, frm_win};
            lem_pkg::A_FRM_THR: rd_mux = frm_thr;
            lem_pkg::A_PER_WIN: rd_mux = per_win;
            lem_pkg::A_PER_THR: rd_mux = per_thr;
            lem_pkg::A_SYM_WIN_LO: rd_mux = sym_win[31:0];
            lem_pkg::A_SYM_WIN_HI: rd_mux = sym_win[63:32];
            lem_pkg::A_SYM_THR_LO: rd_mux = sym_thr[31:0];
            lem_pkg::A_SYM_THR_HI: rd_mux = sym_thr[63:32];
            lem_pkg::A_SEC_WIN: rd_mux = {16'h0, sec_win};
            lem_pkg::A_SEC_THR: rd_mux = {16'h0, sec_thr};
            lem_pkg::A_SEQ: rd_mux = {16'h0, seq_out};
            lem_pkg::A_NOW: rd_mux = {16'h0, now};
            lem_pkg::A_FRM_CNT: rd_mux = frm_cnt;
            lem_pkg::A_FRM_TOT_LO: rd_mux = frm_tot[31:0];
            lem_pkg::A_FRM_TOT_HI: rd_mux = frm_tot[63:32];
            lem_pkg::A_PER_CNT: rd_mux = per_cnt;
            lem_pkg::A_PER_TOT_LO: rd_mux = per_tot[31:0];
            lem_pkg::A_PER_TOT_HI: rd_mux = per_tot[63:32];
            lem_pkg::A_SYM_CNT_LO: rd_mux = sym_cnt[31:0];
            lem_pkg::A_SYM_CNT_HI: rd_mux = sym_cnt[63:32];
            lem_pkg::A_SYM_TOT_LO: rd_mux = sym_tot[31:0];
            lem_pkg::A_SYM_TOT_HI: rd_mux = sym_tot[63:32];
            lem_pkg::A_SEC_CNT: rd_mux = {16'h0, sec_cnt};
            lem_pkg::A_SEC_TOT: rd_mux = sec_tot;
            default: begin
                if (bus_req_in.addr[7:4] == lem_pkg::A_EV_TS[7:4]) begin
                    rd_mux = {16'h0, ev_ts[bus_req_in.addr[3:2]]};
                end else if (bus_req_in.addr[7:4] == lem_pkg::A_EV_CNT[7:4]) begin
                    rd_mux = ev_cnt[bus_req_in.addr[3:2]];
                end
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_out <= '0;
        end else if (ce_in) begin
            rdata_out <= bus_req_in.rd ? rd_mux : 32'h0000_0000;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_seq;
        $past(ce_in) && event_out != 4'h0 |->
            seq_out == $past(seq_out) + 16'($countones(event_out));
    endproperty
    a_seq: assert property (p_seq) else $error("sequence mismatch"); // [RULE1]

    property p_ts;
        $past(ce_in) && event_out[lem_pkg::EV_FRM] |->
            ev_ts[lem_pkg::EV_FRM] == $past(now);
    endproperty
    a_ts: assert property (p_ts) else $error("bad frame stamp"); // [RULE2]

    property p_win;
        frm_win >= lem_pkg::FRM_WIN_MIN && frm_win <= lem_pkg::FRM_WIN_MAX;
    endproperty
    a_win: assert property (p_win) else $error("frame window range"); // [RULE3]

    property p_frm_ev;
        $past(ce_in) && event_out[lem_pkg::EV_FRM] |->
            $past(frm_end) && frm_cnt == 32'h0 &&
            $past(next_frm_cnt) >= $past(frm_thr);
    endproperty
    a_frm_ev: assert property (p_frm_ev) else $error("frame event"); // [RULE4]

    property p_frm_cnt;
        run && !frm_end && obs_in.frame_err |=>
            frm_cnt == $past(frm_cnt) + 32'h1;
    endproperty
    a_frm_cnt: assert property (p_frm_cnt) else $error("frame count"); // [RULE5]

    property p_frm_tot;
        run && obs_in.frame_err |=> frm_tot == $past(frm_tot) + 64'h1;
    endproperty
    a_frm_tot: assert property (p_frm_tot) else $error("frame total"); // [RULE6]

    property p_frm_evc;
        run && ev_raise[lem_pkg::EV_FRM] |=> event_out[lem_pkg::EV_FRM] &&
            ev_cnt[lem_pkg::EV_FRM] == $past(ev_cnt[lem_pkg::EV_FRM]) + 32'h1;
    endproperty
    a_frm_evc: assert property (p_frm_evc) else $error("frame events"); // [RULE7]

    property p_per_ev;
        $past(ce_in) && event_out[lem_pkg::EV_PER] |->
            $past(per_end) && per_cnt == 32'h0;
    endproperty
    a_per_ev: assert property (p_per_ev) else $error("period event"); // [RULE9]

    property p_sym_tot;
        run && obs_in.symbol_err |=> sym_tot == $past(sym_tot) + 64'h1;
    endproperty
    a_sym_tot: assert property (p_sym_tot) else $error("symbol total"); // [RULE16]

    property p_sec_ev;
        $past(ce_in) && event_out[lem_pkg::EV_SEC] |->
            $past(tick) && sec_cnt == 16'h0;
    endproperty
    a_sec_ev: assert property (p_sec_ev) else $error("seconds event"); // [RULE18]

    property p_oam;
        ce_in && oam_reset_in |=> frm_tot == 64'h0 && per_tot == 64'h0 &&
            sym_tot == 64'h0 && sec_tot == 32'h0 && event_out == 4'h0;
    endproperty
    a_oam: assert property (p_oam) else $error("totals not cleared"); // [RULE20]

    c_frm: cover property (event_out[lem_pkg::EV_FRM]);
    c_per: cover property (event_out[lem_pkg::EV_PER]);
    c_sym: cover property (event_out[lem_pkg::EV_SYM]);
    c_sec: cover property (event_out[lem_pkg::EV_SEC]);
endmodule : lem_monitor
`default_nettype wire

// *** design/lem_pkg.sv ***
// Constants and types for the link error event monitor
// Notes on behaviour
// [RULE1] 16-bit sequence counts all raised events
// [RULE2] Events stamped with free-running 100 ms count
// [RULE3] Frame window in 100 ms, 1 s..1 min
// [RULE4] Frame event when count >= 32-bit threshold
// [RULE5] 32-bit errored frames in current frame window
// [RULE6] 64-bit errored frame total since OAM reset
// [RULE7] 32-bit count of frame events
// [RULE8] Period window counts received frames, 32-bit
// [RULE9] Period event when count >= 32-bit threshold
// [RULE10] 32-bit frame errors in current period window
// [RULE11] 64-bit period error total since OAM reset
// [RULE12] 32-bit count of period events
// [RULE13] Symbol window counts received symbols, 64-bit
// [RULE14] Symbol event when count >= 64-bit threshold
// [RULE15] 64-bit symbol errors in current window
// [RULE16] 64-bit symbol error total since OAM reset
// [RULE17] 32-bit count of symbol events
// [RULE18] Seconds event when errored seconds >= threshold
// [RULE19] 16-bit errored seconds in current window
// [RULE20] Window end: compare, clear, restart; reset totals
// [RULE21] Second errored if any errored frame
package lem_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned TICK_MS = 100;
    localparam int unsigned TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [3:0] TICKS_PER_SEC = 4'hA;

    localparam logic [15:0] FRM_WIN_MIN = 16'h000A;
    localparam logic [15:0] FRM_WIN_MAX = 16'h0258;
    localparam logic [15:0] FRM_WIN_RST = 16'h000A;
    localparam logic [31:0] FRM_THR_RST = 32'h0000_0001;
    localparam logic [31:0] PER_WIN_RST = 32'h0000_2710;
    localparam logic [31:0] PER_THR_RST = 32'h0000_0001;
    localparam logic [63:0] SYM_WIN_RST = 64'h0000_0000_05F5_E100;
    localparam logic [63:0] SYM_THR_RST = 64'h0000_0000_0000_0001;
    localparam logic [15:0] SEC_WIN_RST = 16'h0258;
    localparam logic [15:0] SEC_THR_RST = 16'h0001;

    localparam int unsigned NUM_EV = 4;
    localparam int unsigned EV_FRM = 0;
    localparam int unsigned EV_PER = 1;
    localparam int unsigned EV_SYM = 2;
    localparam int unsigned EV_SEC = 3;

    localparam logic [7:0] A_FRM_WIN = 8'h00;
    localparam logic [7:0] A_FRM_THR = 8'h04;
    localparam logic [7:0] A_PER_WIN = 8'h08;
    localparam logic [7:0] A_PER_THR = 8'h0C;
    localparam logic [7:0] A_SYM_WIN_LO = 8'h10;
    localparam logic [7:0] A_SYM_WIN_HI = 8'h14;
    localparam logic [7:0] A_SYM_THR_LO = 8'h18;
    localparam logic [7:0] A_SYM_THR_HI = 8'h1C;
    localparam logic [7:0] A_SEC_WIN = 8'h20;
    localparam logic [7:0] A_SEC_THR = 8'h24;
    localparam logic [7:0] A_SEQ = 8'h28;
    localparam logic [7:0] A_NOW = 8'h2C;
    localparam logic [7:0] A_FRM_CNT = 8'h30;
    localparam logic [7:0] A_FRM_TOT_LO = 8'h34;
    localparam logic [7:0] A_FRM_TOT_HI = 8'h38;
    localparam logic [7:0] A_PER_CNT = 8'h3C;
    localparam logic [7:0] A_PER_TOT_LO = 8'h40;
    localparam logic [7:0] A_PER_TOT_HI = 8'h44;
    localparam logic [7:0] A_SYM_CNT_LO = 8'h48;
    localparam logic [7:0] A_SYM_CNT_HI = 8'h4C;
    localparam logic [7:0] A_SYM_TOT_LO = 8'h50;
    localparam logic [7:0] A_SYM_TOT_HI = 8'h54;
    localparam logic [7:0] A_SEC_CNT = 8'h58;
    localparam logic [7:0] A_SEC_TOT = 8'h5C;
    localparam logic [7:0] A_EV_TS = 8'h60;
    localparam logic [7:0] A_EV_CNT = 8'h70;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } lem_bus_req_t;

    typedef struct packed {
        logic frame;
        logic frame_err;
        logic symbol;
        logic symbol_err;
    } lem_port_obs_t;
endpackage : lem_pkg

// *** test/lem_obs_gen.sv ***
// Port error-detection path model: received frames and symbols
`timescale 1ns/1ns
`default_nettype none
module lem_obs_gen (
    input wire logic sys_clk_in,
    output var lem_pkg::lem_port_obs_t obs_out
);
    initial obs_out = '0;

    // One unit per call, pulses one cycle wide with a gap after
    // An errored frame is also a received frame, likewise symbols
    task automatic send(input logic sym, input logic err);
        @(posedge sys_clk_in);
        obs_out <= sym ? {2'b00, 1'b1, err} : {1'b1, err, 2'b00};
        @(posedge sys_clk_in);
        obs_out <= '0;
    endtask : send
endmodule : lem_obs_gen
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the link error event monitor
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int unsigned TICKS = 8;
    logic sys_clk_in;
    logic reset_n_in;
    logic ce_in;
    logic oam_reset_in;
    lem_pkg::lem_port_obs_t obs;
    lem_pkg::lem_bus_req_t bus;
    logic [31:0] rdata_out;
    logic [3:0] event_out;
    logic [15:0] seq_out;
    int bad_count;
    int total_checks;
    int seed;
    int ev_seen [4];
    int exp_ev [4];
    int exp_seq;
    int n;
    logic [31:0] r;
    logic [31:0] r2;
    logic [7:0] def_a [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
        8'h18, 8'h1C, 8'h20, 8'h24, 8'hFC};
    logic [31:0] def_v [11] = '{32'h0000_000A, 32'h0000_0001,
        lem_pkg::PER_WIN_RST, lem_pkg::PER_THR_RST,
        lem_pkg::SYM_WIN_RST[31:0], lem_pkg::SYM_WIN_RST[63:32],
        32'h0000_0001, 32'h0000_0000, 32'h0000_0258, 32'h0000_0001,
        32'h0000_0000};

    lem_monitor #(.TICK_CYCLES(TICKS)) dut_u (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .ce_in(ce_in),
        .oam_reset_in(oam_reset_in),
        .obs_in(obs),
        .bus_req_in(bus),
        .rdata_out(rdata_out),
        .event_out(event_out),
        .seq_out(seq_out)
    );

    lem_obs_gen gen_u (
        .sys_clk_in(sys_clk_in),
        .obs_out(obs)
    );

    always #50 sys_clk_in = ~sys_clk_in;

    // Count every event pulse per kind
    always @(posedge sys_clk_in) begin
        for (int i = 0; i < 4; i++) begin
            if (event_out[i] === 1'b1) begin
                ev_seen[i] <= ev_seen[i] + 1;
            end
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t ns: saw %h, want %h", $time, seen,
                exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk_in);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk_in);
        bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge sys_clk_in);
        bus.rd <= 1'b0;
        @(negedge sys_clk_in);
        d = rdata_out;
    endtask : rd

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        check(d, exp);
    endtask : rdc

    task automatic sends(input logic sym, input logic [7:0] errs,
        input int cnt);
        for (int i = 0; i < cnt; i++) begin
            gen_u.send(sym, errs[i]);
        end
    endtask : sends

    // Expect one more event of kind k within lim cycles
    task automatic expect_ev(input int k, input int lim);
        int i;
        exp_ev[k]++;
        exp_seq++;
        for (i = 0; i < lim && ev_seen[k] != exp_ev[k]; i++) begin
            @(negedge sys_clk_in);
        end
        check(ev_seen[k], exp_ev[k]);
        check(seq_out, exp_seq[15:0]);
        if (ev_seen[k] != exp_ev[k]) begin
            print_verdict();
        end
    endtask : expect_ev

    // No event of kind k over cyc cycles
    task automatic quiet(input int k, input int cyc);
        repeat (cyc) @(negedge sys_clk_in);
        check(ev_seen[k], exp_ev[k]);
    endtask : quiet

    initial begin
        sys_clk_in = 1'b0;
        reset_n_in = 1'b0;
        ce_in = 1'b1;
        oam_reset_in = 1'b0;
        bus = '0;
        bad_count = 0;
        total_checks = 0;
        seed = 94;
        exp_seq = 0;
        for (int i = 0; i < 4; i++) begin
            ev_seen[i] = 0;
            exp_ev[i] = 0;
        end
        repeat (10) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            rdc(def_a[i], def_v[i]);
        end
        wr(lem_pkg::A_FRM_WIN, 32'h0000_0005);
        rdc(lem_pkg::A_FRM_WIN, 32'h0000_000A);
        wr(lem_pkg::A_FRM_WIN, 32'h0000_03E8);
        rdc(lem_pkg::A_FRM_WIN, 32'h0000_0258);
        wr(lem_pkg::A_FRM_WIN, 32'h0000_000A);
        wr(lem_pkg::A_SEQ, 32'h0000_1234);
        rdc(lem_pkg::A_SEQ, 32'h0000_0000);
        wr(lem_pkg::A_SEC_THR, 32'h0000_FFFF);
        wr(lem_pkg::A_FRM_THR, 32'hFFFF_FFFF);
        // Symbol window of 5, threshold 3
        wr(lem_pkg::A_SYM_WIN_LO, 32'h0000_0005);
        wr(lem_pkg::A_SYM_THR_LO, 32'h0000_0003);
        sends(1'b1, 8'h0B, 5);
        expect_ev(2, 6);
        rdc(lem_pkg::A_SYM_CNT_LO, 32'h0000_0000);
        sends(1'b1, 8'h09, 5);
        quiet(2, 4);
        rdc(lem_pkg::A_SYM_TOT_LO, 32'h0000_0005);
        rdc(lem_pkg::A_EV_CNT + 8'h08, 32'h0000_0001);
        // Period window of 4 frames, threshold 2
        wr(lem_pkg::A_PER_WIN, 32'h0000_0004);
        wr(lem_pkg::A_PER_THR, 32'h0000_0002);
        sends(1'b0, 8'h05, 4);
        expect_ev(1, 6);
        rdc(lem_pkg::A_PER_CNT, 32'h0000_0000);
        sends(1'b0, 8'h04, 4);
        quiet(1, 4);
        rdc(lem_pkg::A_PER_TOT_LO, 32'h0000_0003);
        rdc(lem_pkg::A_EV_CNT + 8'h04, 32'h0000_0001);
        wr(lem_pkg::A_PER_THR, 32'hFFFF_FFFF);
        // Zero threshold fires every window and gives the window phase
        wr(lem_pkg::A_FRM_THR, 32'h0000_0000);
        expect_ev(0, 200);
        n = 1 + ($unsigned($random(seed)) % 4);
        wr(lem_pkg::A_FRM_THR, n);
        sends(1'b0, 8'hFF, n);
        expect_ev(0, 120);
        rd(lem_pkg::A_EV_TS, r);
        rd(lem_pkg::A_NOW, r2);
        check(64'(r2[15:0] - r[15:0] <= 16'h0002), 64'h1);
        rdc(lem_pkg::A_FRM_CNT, 32'h0000_0000);
        sends(1'b0, 8'hFF, n - 1);
        quiet(0, 85);
        rdc(lem_pkg::A_FRM_TOT_LO, 32'(n + n + 2));
        rdc(lem_pkg::A_EV_CNT, 32'h0000_0002);
        wr(lem_pkg::A_FRM_THR, 32'hFFFF_FFFF);
        // Sublayer reset clears totals and the sequence count
        @(posedge sys_clk_in);
        oam_reset_in <= 1'b1;
        @(posedge sys_clk_in);
        oam_reset_in <= 1'b0;
        exp_seq = 0;
        @(negedge sys_clk_in);
        check(seq_out, 64'h0);
        rdc(lem_pkg::A_FRM_TOT_LO, 32'h0000_0000);
        rdc(lem_pkg::A_EV_CNT, 32'h0000_0000);
        // One errored frame makes exactly one errored second
        wr(lem_pkg::A_SEC_WIN, 32'h0000_0014);
        wr(lem_pkg::A_SEC_THR, 32'h0000_0001);
        sends(1'b0, 8'h01, 1);
        expect_ev(3, 400);
        rdc(lem_pkg::A_SEC_CNT, 32'h0000_0000);
        quiet(3, 200);
        check(seq_out, 64'h1);
        rdc(lem_pkg::A_SEC_TOT, 32'h0000_0001);
        // Clock enable low freezes the timestamp
        rd(lem_pkg::A_NOW, r);
        @(posedge sys_clk_in);
        ce_in <= 1'b0;
        repeat (40) @(posedge sys_clk_in);
        ce_in <= 1'b1;
        rd(lem_pkg::A_NOW, r2);
        check(64'(r2[15:0] - r[15:0] <= 16'h0001), 64'h1);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
